// File: hdl/ttppm_pkg.sv
// constants and types of the periodic microframe pipeline manager
`default_nettype none

package ttppm_pkg;

	// ------------------------------------------------------------------
	// pipeline sizes
	// ------------------------------------------------------------------
	localparam int SS_DEPTH = 16;             // start-split slots
	localparam int SLOT_W   = 4;              // slot index width
	localparam int UF_W     = 3;              // microframe position width
	localparam int CNT_W    = 5;              // width of a 0..16 count
	localparam logic [CNT_W-1:0] CS_DEPTH = 5'h10; // results per microframe

	// ------------------------------------------------------------------
	// microframe positions and ages
	// ------------------------------------------------------------------
	localparam logic [UF_W-1:0] FRAME_SLOT_ZERO = 3'h0;
	localparam logic [UF_W-1:0] FRAME_SLOT_SIX  = 3'h6;
	// microframe just before the first one of a frame
	localparam logic [UF_W-1:0] FRAME_SLOT_PREV = FRAME_SLOT_ZERO - 3'h1;
	// a start-split this many microframes old is stale
	localparam logic [UF_W-1:0] STALE_AGE       = 3'h4;

	// ------------------------------------------------------------------
	// downstream transaction phase, reported by the bus handler
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		PH_IDLE  = 2'b00,  // token not yet started
		PH_TOKEN = 2'b01,  // token sent, data not started
		PH_DATA  = 2'b10,  // data packet on the wire
		PH_HSK   = 2'b11   // handshake started
	} ttppm_phase_e;

	// ------------------------------------------------------------------
	// downstream issue state
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		DS_IDLE  = 2'b00,  // free to start a transaction
		DS_RUN   = 2'b01,  // transaction running normally
		DS_DRAIN = 2'b10   // aborted, waiting for the handler to finish
	} ttppm_ds_e;

endpackage

`default_nettype wire

// File: hdl/ttppm_abort_if.sv
// carrier between the pipeline manager and its abort decoder
`default_nettype none

interface ttppm_abort_if;
	import ttppm_pkg::*;

	logic         abort;      // one-cycle abort request
	logic         is_in;      // running transaction is an IN
	ttppm_phase_e phase;      // downstream phase at the abort
	logic         skip_token; // do not send the token
	logic         skip_data;  // do not send the OUT data packet
	logic         stuff_err;  // cut the OUT data with a stuffing error
	logic         no_hsk;     // send no downstream handshake
	logic         discard;    // throw away received IN data

	modport ctl (
		output abort,
		output is_in,
		output phase,
		input  skip_token,
		input  skip_data,
		input  stuff_err,
		input  no_hsk,
		input  discard
	);

	modport dec (
		input  abort,
		input  is_in,
		input  phase,
		output skip_token,
		output skip_data,
		output stuff_err,
		output no_hsk,
		output discard
	);

endinterface

`default_nettype wire

// File: hdl/ttppm_abort.sv
// decoder turning an abort into downstream bus actions
`default_nettype none

module ttppm_abort
	import ttppm_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst_n,
	ttppm_abort_if.dec ab
);

	// ------------------------------------------------------------------
	// action decode
	// ------------------------------------------------------------------
	// an abort after the handshake started changes nothing on the wire
	wire logic pre_tok  = ab.phase == PH_IDLE;
	wire logic in_tok   = ab.phase == PH_TOKEN;
	wire logic in_data  = ab.phase == PH_DATA;
	wire logic tok_nxt  = ab.abort & pre_tok;
	wire logic dat_nxt  = ab.abort & ~ab.is_in & (pre_tok | in_tok);
	wire logic stf_nxt  = ab.abort & ~ab.is_in & in_data;
	// IN: the device packet is let run to its end, then dropped
	wire logic hsk_nxt  = ab.abort & ab.is_in
	                      & (ab.phase != PH_HSK);
	wire logic dis_nxt  = ab.abort & ab.is_in & (in_tok | in_data);

	// ------------------------------------------------------------------
	// registered one-cycle action pulses
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ab.skip_token <= 1'b0;
			ab.skip_data  <= 1'b0;
			ab.stuff_err  <= 1'b0;
			ab.no_hsk     <= 1'b0;
			ab.discard    <= 1'b0;
		end else begin
			ab.skip_token <= tok_nxt;
			ab.skip_data  <= dat_nxt;
			ab.stuff_err  <= stf_nxt;
			ab.no_hsk     <= hsk_nxt;
			ab.discard    <= dis_nxt;
		end
	end

endmodule

`default_nettype wire

// File: hdl/ttppm_top.sv
// periodic microframe pipeline manager of a transaction translator
// all inputs come from logic on ref_clk and are used without synchronisers
`default_nettype none

module ttppm_top
	import ttppm_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// microframe and frame timers
	input  wire logic              uframe_tick,
	input  wire logic [UF_W-1:0]   uframe_num,
	input  wire logic              fs_eof,
	// start-splits arriving from the high-speed side
	input  wire logic              ss_valid,
	input  wire logic              ss_is_intr,
	input  wire logic              ss_is_in,
	output logic                   ss_ready,
	output logic                   ss_ack,
	output logic [SLOT_W-1:0]      ss_ack_slot,
	// complete-split lookup from the high-speed side
	input  wire logic              cs_query,
	input  wire logic [SLOT_W-1:0] cs_query_slot,
	output logic                   cs_resp_valid,
	output logic                   cs_resp_hit,
	// downstream full-/low-speed handler
	output logic                   ds_go,
	output logic [SLOT_W-1:0]      ds_slot,
	output logic                   ds_is_in,
	output logic                   ds_is_intr,
	input  wire logic [1:0]        ds_phase,
	input  wire logic              ds_done,
	input  wire logic              ds_ok,
	output logic                   ds_abort,
	output logic                   ds_skip_token,
	output logic                   ds_skip_data,
	output logic                   ds_stuff_err,
	output logic                   ds_no_hsk,
	output logic                   ds_discard
);

	// ------------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------------
	// lowest set bit of a slot vector
	function automatic logic [SLOT_W-1:0] first_set(
		input logic [SS_DEPTH-1:0] v
	);
		logic [SLOT_W-1:0] idx;
		idx = '0;
		for (int i = SS_DEPTH - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = SLOT_W'(i);
			end
		end
		return idx;
	endfunction

	// number of results held in one complete-split bank
	function automatic logic [CNT_W-1:0] count_set(
		input logic [SS_DEPTH-1:0] v
	);
		logic [CNT_W-1:0] n;
		n = '0;
		for (int i = 0; i < SS_DEPTH; i++) begin
			n = n + CNT_W'(v[i]);
		end
		return n;
	endfunction

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic [SS_DEPTH-1:0] ent_valid_r;   // slot holds a buffered start-split
	logic [SS_DEPTH-1:0] ent_pend_r;    // slot is eligible to run
	logic [SS_DEPTH-1:0] ent_intr_r;
	logic [SS_DEPTH-1:0] ent_in_r;
	logic [UF_W-1:0]     ent_rx_r [SS_DEPTH];
	logic [SS_DEPTH-1:0] cs_cur_r;      // results gathered this microframe
	logic [SS_DEPTH-1:0] cs_prev_r;     // results awaiting complete-splits
	logic [UF_W-1:0]     cur_uf_r;      // position of the current microframe
	ttppm_ds_e           ds_st_r;
	logic [SLOT_W-1:0]   run_slot_r;

	logic [SS_DEPTH-1:0] ent_valid_nxt;
	logic [SS_DEPTH-1:0] ent_pend_nxt;
	logic [SS_DEPTH-1:0] cs_cur_nxt;
	logic [SS_DEPTH-1:0] cs_prev_nxt;
	ttppm_ds_e           ds_st_nxt;

	ttppm_abort_if ab_if ();

	// ------------------------------------------------------------------
	// per-slot free and pending decode
	// ------------------------------------------------------------------
	// stale frees are judged against the new microframe position, EOF frees against FRAME_SLOT_PREV
	logic [SS_DEPTH-1:0] stale_w;
	logic [SS_DEPTH-1:0] eof_free_w;
	logic [SS_DEPTH-1:0] mark_w;
	logic [SS_DEPTH-1:0] done_bit_w;
	logic [SS_DEPTH-1:0] issue_bit_w;
	logic [SS_DEPTH-1:0] alloc_bit_w;

	generate
		for (genvar g = 0; g < SS_DEPTH; g++) begin : g_slot
			wire logic [UF_W-1:0] age = uframe_num - ent_rx_r[g];
			assign stale_w[g]    = uframe_tick & ent_valid_r[g]
			                       & (age >= STALE_AGE);
			assign eof_free_w[g] = fs_eof & ent_valid_r[g]
			                       & (ent_rx_r[g] != FRAME_SLOT_PREV);
			// only slots received before the tick become pending
			assign mark_w[g]     = uframe_tick & ent_valid_r[g]
			                       & ~stale_w[g] & ~eof_free_w[g];
		end
	endgenerate

	// ------------------------------------------------------------------
	// downstream issue and abort decode
	// ------------------------------------------------------------------
	wire logic [CNT_W-1:0] cs_used = count_set(cs_cur_r);
	wire logic cs_room  = cs_used < CS_DEPTH;
	wire logic [SS_DEPTH-1:0] ready_w = ent_valid_r & ent_pend_r;
	wire logic [SLOT_W-1:0] pick = first_set(ready_w);
	// no start during the advance so the new state is seen first
	wire logic issue = (ds_st_r == DS_IDLE) & (|ready_w) & cs_room
	                   & ~uframe_tick & ~fs_eof;
	wire logic running = ds_st_r == DS_RUN;
	wire logic abort = running & (fs_eof | stale_w[run_slot_r]);
	// a completion in the abort cycle still counts as aborted
	wire logic done_good = running & ds_done & ds_ok & ~abort;
	wire logic done_any  = running & ds_done & ~abort;

	assign done_bit_w  = done_good ? (SS_DEPTH'(1) << run_slot_r) : '0;
	assign issue_bit_w = issue ? (SS_DEPTH'(1) << pick) : '0;

	// ------------------------------------------------------------------
	// start-split allocation
	// ------------------------------------------------------------------
	wire logic [SLOT_W-1:0] free_slot = first_set(~ent_valid_r);
	wire logic take = ss_valid & ss_ready;
	assign alloc_bit_w = take ? (SS_DEPTH'(1) << free_slot) : '0;
	// a start-split at the tick belongs to the new microframe
	wire logic [UF_W-1:0] rx_pos = uframe_tick ? uframe_num : cur_uf_r;

	// ------------------------------------------------------------------
	// slot next state: frees first, then pending marks, then new arrivals
	// ------------------------------------------------------------------
	wire logic [SS_DEPTH-1:0] run_bit_w =
		(running & done_any) | abort ? (SS_DEPTH'(1) << run_slot_r) : '0;
	wire logic [SS_DEPTH-1:0] free_all = stale_w | eof_free_w
	                                     | run_bit_w;
	assign ent_valid_nxt = (ent_valid_r & ~free_all) | alloc_bit_w;
	assign ent_pend_nxt  = ((ent_pend_r | mark_w) & ~free_all
	                        & ~issue_bit_w);

	// ------------------------------------------------------------------
	// complete-split banks: old results go, new bank starts empty
	// ------------------------------------------------------------------
	assign cs_prev_nxt = uframe_tick ? (cs_cur_r | done_bit_w)
	                                 : cs_prev_r;
	assign cs_cur_nxt  = uframe_tick ? '0 : (cs_cur_r | done_bit_w);

	// ------------------------------------------------------------------
	// lookup answer, judged on the state after any advance in this cycle
	// ------------------------------------------------------------------
	wire logic hit_nxt = cs_prev_nxt[cs_query_slot];

	// ------------------------------------------------------------------
	// downstream state machine
	// ------------------------------------------------------------------
	always_comb begin
		ds_st_nxt = ds_st_r;
		case (ds_st_r)
			DS_IDLE: begin
				if (issue) begin
					ds_st_nxt = DS_RUN;
				end
			end
			DS_RUN: begin
				if (abort) begin
					ds_st_nxt = ds_done ? DS_IDLE : DS_DRAIN;
				end else if (ds_done) begin
					ds_st_nxt = DS_IDLE;
				end
			end
			DS_DRAIN: begin
				// handler ends the packet; its result is dropped
				if (ds_done) begin
					ds_st_nxt = DS_IDLE;
				end
			end
			default: begin
				ds_st_nxt = DS_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// abort decoder hookup
	// ------------------------------------------------------------------
	assign ab_if.abort = abort;
	assign ab_if.is_in = ent_in_r[run_slot_r];
	assign ab_if.phase = ttppm_phase_e'(ds_phase);

	ttppm_abort u_abort (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.ab      (ab_if.dec)
	);

	assign ds_skip_token = ab_if.skip_token;
	assign ds_skip_data  = ab_if.skip_data;
	assign ds_stuff_err  = ab_if.stuff_err;
	assign ds_no_hsk     = ab_if.no_hsk;
	assign ds_discard    = ab_if.discard;

	// ------------------------------------------------------------------
	// pipeline registers
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ent_valid_r <= '0;
			ent_pend_r  <= '0;
			cs_cur_r    <= '0;
			cs_prev_r   <= '0;
			cur_uf_r    <= FRAME_SLOT_ZERO;
			ds_st_r     <= DS_IDLE;
		end else begin
			ent_valid_r <= ent_valid_nxt;
			ent_pend_r  <= ent_pend_nxt;
			cs_cur_r    <= cs_cur_nxt;
			cs_prev_r   <= cs_prev_nxt;
			ds_st_r     <= ds_st_nxt;
			if (uframe_tick) begin
				cur_uf_r <= uframe_num;
			end
		end
	end

	// slot attributes need no reset: the valid bit guards them
	always_ff @(posedge ref_clk) begin
		if (take) begin
			ent_rx_r[free_slot]   <= rx_pos;
			ent_intr_r[free_slot] <= ss_is_intr;
			ent_in_r[free_slot]   <= ss_is_in;
		end
	end

	// ------------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ss_ready      <= 1'b0;
			ss_ack        <= 1'b0;
			ss_ack_slot   <= '0;
			cs_resp_valid <= 1'b0;
			cs_resp_hit   <= 1'b0;
			ds_go         <= 1'b0;
			ds_slot       <= '0;
			ds_is_in      <= 1'b0;
			ds_is_intr    <= 1'b0;
			ds_abort      <= 1'b0;
			run_slot_r    <= '0;
		end else begin
			ss_ready      <= ~&ent_valid_nxt;
			ss_ack        <= take;
			ss_ack_slot   <= free_slot;
			cs_resp_valid <= cs_query;
			cs_resp_hit   <= cs_query & hit_nxt;
			ds_go         <= issue;
			ds_abort      <= abort;
			if (issue) begin
				ds_slot    <= pick;
				ds_is_in   <= ent_in_r[pick];
				ds_is_intr <= ent_intr_r[pick];
				run_slot_r <= pick;
			end
		end
	end

endmodule

`default_nettype wire

// File: tb/ttppm_properties.sv
// port-level checks of the periodic pipeline manager
`default_nettype none

module ttppm_properties
	import ttppm_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       uframe_tick,
	input wire logic       fs_eof,
	input wire logic       ss_valid,
	input wire logic       ss_ready,
	input wire logic       ss_ack,
	input wire logic       cs_query,
	input wire logic       cs_resp_valid,
	input wire logic       cs_resp_hit,
	input wire logic       ds_go,
	input wire logic       ds_is_in,
	input wire logic [1:0] ds_phase,
	input wire logic       ds_done,
	input wire logic       ds_abort,
	input wire logic       ds_skip_token,
	input wire logic       ds_skip_data,
	input wire logic       ds_stuff_err,
	input wire logic       ds_no_hsk,
	input wire logic       ds_discard
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	logic busy_r;  // from a start until the handler reports done
	logic run_r;   // as busy_r, but an abort ends it too
	logic running;
	logic any_act;

	// a drain after an abort must not count as running again
	assign running = (ds_go || run_r) && !ds_abort;
	assign any_act = ds_skip_token || ds_skip_data || ds_stuff_err ||
		ds_no_hsk || ds_discard;

	// run tracking seen from the ports only
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			run_r  <= 1'b0;
		end else begin
			busy_r <= ds_go || (busy_r && !ds_done);
			run_r  <= ds_go || (run_r && !ds_done && !ds_abort);
		end
	end

	sequence eof_hit;
		fs_eof && running && !ds_done;
	endsequence

	sequence in_cut;
		ds_abort && ds_is_in;
	endsequence

	sequence out_cut;
		ds_abort && !ds_is_in;
	endsequence

	eof_abort_a: assert property (eof_hit |=> ds_abort)
		else $error("no abort at end of frame");
	in_abort_a: assert property (in_cut |->
		ds_skip_token == ($past(ds_phase) == 2'h0) &&
		ds_no_hsk == ($past(ds_phase) != 2'h3) &&
		ds_discard == ($past(ds_phase) inside {2'h1, 2'h2}) &&
		!ds_skip_data && !ds_stuff_err)
		else $error("wrong IN abort actions");
	out_abort_a: assert property (out_cut |->
		ds_skip_token == ($past(ds_phase) == 2'h0) &&
		ds_skip_data == ($past(ds_phase) <= 2'h1) &&
		ds_stuff_err == ($past(ds_phase) == 2'h2) &&
		!ds_no_hsk && !ds_discard)
		else $error("wrong OUT abort actions");
	action_only_a: assert property (any_act |-> ds_abort)
		else $error("bus action without abort");
	quiet_edge_a: assert property (ds_go |->
		!$past(uframe_tick) && !$past(fs_eof))
		else $error("start decided on a timer edge");
	one_run_a: assert property (ds_go |-> !busy_r)
		else $error("start while busy");
	lookup_ans_a: assert property (cs_resp_valid == $past(cs_query))
		else $error("lookup answer timing");
	hit_valid_a: assert property (cs_resp_hit |-> cs_resp_valid)
		else $error("hit without answer");
	ss_take_a: assert property (ss_ack == $past(ss_valid && ss_ready))
		else $error("start-split ack timing");
endmodule

bind ttppm_top ttppm_properties u_props (.ref_clk, .rst_n,
	.uframe_tick, .fs_eof, .ss_valid, .ss_ready, .ss_ack, .cs_query,
	.cs_resp_valid, .cs_resp_hit, .ds_go, .ds_is_in, .ds_phase, .ds_done,
	.ds_abort, .ds_skip_token, .ds_skip_data, .ds_stuff_err, .ds_no_hsk,
	.ds_discard);

`default_nettype wire

// File: tb/ttppm_fsbus_model.sv
// behavioural full-/low-speed bus handler beside the pipeline manager
`default_nettype none

module ttppm_fsbus_model (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        ds_go,
	input  wire logic        ds_abort,
	input  wire logic [15:0] len,
	input  wire logic        ok_cfg,
	output logic [1:0]       ds_phase,
	output logic             ds_done,
	output logic             ds_ok
);
	timeunit 1ns;
	timeprecision 1ps;

	logic        act_r;  // a transaction is on the bus
	logic        ab_r;   // abort seen, finish quietly
	logic [15:0] cnt_r;  // cycles since start
	logic        quit;

	// phase follows elapsed time; long len gives a slow device
	assign ds_phase = !act_r ? 2'h0 : (cnt_r < 16'h2) ? 2'h0 :
		(cnt_r < 16'h4) ? 2'h1 : (cnt_r < len - 16'h1) ? 2'h2 : 2'h3;
	// a packet already on the wire is let run to its end
	assign quit = (ds_abort || ab_r) && ds_phase != 2'h2;

	// done comes even after an abort, so the manager can idle
	always_ff @(posedge ref_clk) begin
		ds_done <= 1'b0;
		ds_ok   <= 1'b0;
		if (!rst_n) begin
			act_r <= 1'b0;
			ab_r  <= 1'b0;
			cnt_r <= 16'h0;
		end else if (ds_go) begin
			act_r <= 1'b1;
			ab_r  <= 1'b0;
			cnt_r <= 16'h0;
		end else if (act_r) begin
			cnt_r <= cnt_r + 16'h1;
			ab_r  <= ab_r || ds_abort;
			if (cnt_r >= len || quit) begin
				act_r   <= 1'b0;
				ds_done <= 1'b1;
				ds_ok   <= ok_cfg && !quit;
			end
		end
	end
endmodule

`default_nettype wire

// File: tb/ttppm_top_tb.sv
// self-checking bench for the periodic pipeline manager
`default_nettype none

module ttppm_top_tb
	import ttppm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int DLY    = 1;    // drive delay after each edge
	localparam int MAXCYC = 6000; // the scenarios need under 2000

	logic ref_clk = 1'b0, rst_n = 1'b0, uframe_tick = 1'b0, fs_eof = 1'b0;
	logic ss_valid = 1'b0, ss_is_intr = 1'b0, ss_is_in = 1'b0;
	logic cs_query = 1'b0, fs_ok = 1'b1;
	logic [UF_W-1:0]   uframe_num = 3'h0;
	logic [SLOT_W-1:0] cs_query_slot = 4'h0;
	logic [15:0]       fs_len = 16'h3;
	logic ss_ready, ss_ack, cs_resp_valid, cs_resp_hit, ds_go, ds_is_in;
	logic ds_is_intr, ds_done, ds_ok, ds_abort, ds_skip_token;
	logic ds_skip_data, ds_stuff_err, ds_no_hsk, ds_discard;
	logic [SLOT_W-1:0] ss_ack_slot, ds_slot;
	logic [1:0]        ds_phase;
	int error_cnt = 0, checks_done = 0, cyc = 0, go_cnt = 0, ab_cnt = 0;

	ttppm_top u_dut (.ref_clk, .rst_n, .uframe_tick, .uframe_num, .fs_eof,
		.ss_valid, .ss_is_intr, .ss_is_in, .ss_ready, .ss_ack, .ss_ack_slot,
		.cs_query, .cs_query_slot, .cs_resp_valid, .cs_resp_hit, .ds_go,
		.ds_slot, .ds_is_in, .ds_is_intr, .ds_phase, .ds_done, .ds_ok,
		.ds_abort, .ds_skip_token, .ds_skip_data, .ds_stuff_err, .ds_no_hsk,
		.ds_discard);

	ttppm_fsbus_model u_bus (.ref_clk, .rst_n, .ds_go, .ds_abort,
		.len(fs_len), .ok_cfg(fs_ok), .ds_phase, .ds_done, .ds_ok);

	always #10 ref_clk = ~ref_clk;

	// pulse counters; a hung run is cut short here
	always @(posedge ref_clk) begin
		cyc++;
		if (ds_go === 1'b1) go_cnt++;
		if (ds_abort === 1'b1) ab_cnt++;
		if (cyc == MAXCYC) begin
			error_cnt++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (error_cnt == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, exp, input string msg);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t %s seen %0h exp %0h", $time, msg, seen, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#DLY;
	endtask

	// microframe timer moves one position, wrapping after seven
	task automatic tick();
		step(1);
		uframe_tick = 1'b1;
		uframe_num  = uframe_num + 3'h1;
		step(1);
		uframe_tick = 1'b0;
	endtask

	// start-split held until the edge that finds a free slot
	task automatic send(input logic intr, in, output logic [SLOT_W-1:0] s);
		step(1);
		ss_is_intr = intr;
		ss_is_in   = in;
		ss_valid   = 1'b1;
		@(posedge ref_clk);
		while (ss_ready !== 1'b1) @(posedge ref_clk);
		#DLY;
		ss_valid = 1'b0;
		check(16'(ss_ack), 16'h1, "ack");
		s = ss_ack_slot;
	endtask

	task automatic look(input logic [SLOT_W-1:0] slot, input logic hit);
		step(1);
		cs_query      = 1'b1;
		cs_query_slot = slot;
		step(1);
		cs_query = 1'b0;
		check(16'({cs_resp_valid, cs_resp_hit}), {15'h1, hit}, "look");
	endtask

	// sixteen start-splits fill every slot and all run in one microframe
	task automatic t_fill();
		logic [SLOT_W-1:0] s;
		int                g;
		tick();
		for (int i = 0; i < 16; i++) begin
			send(1'b1, 1'b1, s);
			check(16'(s), 16'(i), "slot");
		end
		step(1);
		check(16'(ss_ready), 16'h0, "full");
		g = go_cnt;
		step(20);
		check(16'(go_cnt - g), 16'h0, "early start");
		tick();
		step(200);
		check(16'(go_cnt - g), 16'h10, "starts");
		look(4'h0, 1'b0);
		tick();
		for (int i = 0; i < 16; i++) look(4'(i), 1'b1);
		tick();
		look(4'h0, 1'b0);
		tick();
		step(2);
		check(16'(ss_ready), 16'h1, "freed");
	endtask

	// a slow interrupt IN is cut when its start-split turns four old
	task automatic t_age();
		logic [SLOT_W-1:0] s;
		int                a;
		fs_len = 16'h12C;
		send(1'b1, 1'b1, s);
		tick();
		step(10);
		check(16'(ds_slot), 16'(s), "run slot");
		check(16'({ds_is_intr, ds_is_in}), 16'h3, "run kind");
		a = ab_cnt;
		tick();
		tick();
		step(2);
		check(16'(ab_cnt - a), 16'h0, "abort early");
		tick();
		check(16'({ds_no_hsk, ds_discard}), 16'h3, "in cut");
		step(2);
		check(16'(ab_cnt - a), 16'h1, "age abort");
		step(300);
		tick();
		look(s, 1'b0);
	endtask

	// end of frame cuts an OUT in its data and keeps only slot-seven splits
	task automatic t_eof();
		logic [SLOT_W-1:0] a, b, c, o;
		int                n;
		tick();
		tick();
		tick();
		send(1'b0, 1'b0, a);
		send(1'b0, 1'b0, b);
		tick();
		step(10);
		o = (ds_slot === a) ? b : a;
		tick();
		send(1'b1, 1'b0, c); // nothing is sent in slot six
		n = ab_cnt;
		step(1);
		fs_eof = 1'b1;
		step(1);
		fs_eof = 1'b0;
		check(16'({ds_skip_data, ds_stuff_err}), 16'h1, "stuff");
		step(2);
		check(16'(ab_cnt - n), 16'h1, "eof abort");
		step(300);
		n = go_cnt;
		tick();
		step(10);
		check(16'(go_cnt - n), 16'h1, "eof keep");
		check(16'(ds_slot), 16'(c), "kept slot");
		check(16'({ds_is_intr, ds_is_in}), 16'h2, "kept kind");
		tick();
		look(o, 1'b0);
	endtask

	// end of frame cuts an IN before its token and an OUT after it;
	// then a run that ends without a result must still answer NYET
	task automatic t_early();
		logic [SLOT_W-1:0] s;
		int                n;
		fs_len = 16'h8;
		step(20);
		send(1'b0, 1'b1, s);
		tick();
		n = ab_cnt;
		step(1);
		fs_eof = 1'b1;
		step(1);
		fs_eof = 1'b0;
		check(16'({ds_skip_token, ds_no_hsk, ds_discard}), 16'h6, "tok");
		step(2);
		check(16'(ab_cnt - n), 16'h1, "token abort");
		send(1'b0, 1'b0, s);
		tick();
		step(4);
		fs_eof = 1'b1;
		step(1);
		fs_eof = 1'b0;
		check(16'({ds_skip_data, ds_stuff_err}), 16'h2, "dat");
		send(1'b1, 1'b1, s);
		fs_ok = 1'b0;
		n = go_cnt;
		tick();
		step(20);
		fs_ok = 1'b1;
		check(16'(go_cnt - n), 16'h1, "bad run");
		tick();
		look(s, 1'b0);
	endtask

	initial begin
		repeat (12) @(posedge ref_clk);
		#DLY;
		rst_n = 1'b1;
		step(1);
		t_fill();
		t_age();
		t_eof();
		t_early();
		stop_test();
	end
endmodule

`default_nettype wire
